//--- hdl/boot_addr_map.sv
// Decodes destination addresses into code/xdata RAM and internal RAM writes
module boot_addr_map (
   input wire logic clk,        // System clock
   input wire logic rst_n,      // Synchronous reset
   boot_wr_if.map wr            // Request in, RAM writes out
);
   import boot_pkg::*;

   logic inWin;
   logic inWritable;

   assign inWin = (wr.addr >= IWIN_LO) && (wr.addr <= IWIN_HI);
   // Clearing reaches the whole window; frame loads only the middle part
   assign inWritable = wr.clr || ((wr.addr >= IWR_LO) && (wr.addr <= IWR_HI));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr.xWe <= 1'b0;
         wr.xAddr <= 13'h0000;
         wr.xData <= 8'h00;
         wr.iWe <= 1'b0;
         wr.iAddr <= 8'h00;
         wr.iData <= 8'h00;
         wr.drop <= 1'b0;
      end else begin
         wr.xWe <= 1'b0;
         wr.iWe <= 1'b0;
         wr.drop <= 1'b0;
         if (wr.req) begin
            if (wr.addr <= XRAM_HI) begin
               wr.xWe <= 1'b1;
               wr.xAddr <= wr.addr[12:0];
               wr.xData <= wr.data;
            end else if (inWin && inWritable) begin
               // Only the indirect space: no path reaches the SFRs
               wr.iWe <= 1'b1;
               wr.iAddr <= wr.addr[7:0];
               wr.iData <= wr.data;
            end else begin
               wr.drop <= 1'b1;
            end
         end
      end
   end
endmodule

//--- hdl/boot_loader_retest_protection.sv
// Boot loader: frame copy, retest detection and retest protection
// Function
// - Write each frame byte to its address
// - 0x0000-0x11FF goes to code/xdata RAM
// - 0x7000-0x70FF maps to internal RAM low byte
// - Only 0x7020-0x70EF writable in that window
// - Never write special-function registers this way
// - Load first and all appended user blocks
// - Run state keeps debug port closed
// - Retest pin sequence: load factory region only
// - Finish flag actions before opening debug port
// - Ignore protection flags unless part is Run
// - Kill flag: never open, ignore others (code honours the kill flag only at Run level)
// - RAM clear zeroes xdata RAM below factory
// - RAM clear zeroes internal RAM above bank 0
// - EEPROM lock flag sets EEPROM lock bit
// - Locked EEPROM reads zero, writes discarded
// - NVM lock flag sets NVM lock at end
// - Locked NVM still allows both CRC computations
// - Locked NVM allows only last 64 reads
// - Stored flags fixed; no setting in Run
// - Bits 7/6/5 NVM/EEPROM/RAM, write-once
module boot_loader_retest_protection #(
   parameter logic [15:0] XRAM_FACTORY_BASE = boot_pkg::XRAM_FACTORY_BASE_DEF, // First factory byte
   parameter int NVM_BYTES = boot_pkg::NVM_BYTES_DEF,                         // NVM size in bytes
   parameter int SEQ_LEN = boot_pkg::SEQ_LEN_DEF,                             // Retest pattern length
   parameter logic [3:0] RETEST_SEQ = boot_pkg::RETEST_SEQ_DEF                 // Retest pin pattern
) (
   input wire logic clk,                       // 40 MHz system clock
   input wire logic rst_n,                     // Synchronous reset, active low
   input wire logic bootStart,                 // Pulse: begin boot
   input wire boot_pkg::level_t progLevel,     // Programming level
   input wire logic retestPin,                 // Tester pin, asynchronous
   input wire logic [7:0] protNvmByte,         // Retest protection byte from NVM
   input wire logic debugPortKill,             // Permanent debug port kill flag
   input wire logic protWrReq,                 // Pulse: program protection bits
   input wire logic [7:0] protWrData,          // Bits to program
   input wire logic frameValid,                // Frame byte valid
   input wire logic [15:0] frameAddr,          // Frame byte destination
   input wire logic [7:0] frameData,           // Frame byte payload
   input wire logic frameUser,                 // Byte belongs to a user block
   input wire logic frameEnd,                  // Last byte of the image
   input wire logic [7:0] eeRdData,            // EEPROM read data
   input wire logic eeWrReq,                   // EEPROM write request
   input wire logic nvmReqValid,               // NVM operation request
   input wire boot_pkg::nvm_op_t nvmReqKind,   // NVM operation kind
   input wire logic [12:0] nvmReqAddr,         // NVM read address
   output logic frameReady,                    // Loader takes frame bytes
   output logic xramWe,                        // Code/xdata RAM write strobe
   output logic [12:0] xramAddr,               // Code/xdata RAM address
   output logic [7:0] xramData,                // Code/xdata RAM data
   output logic iramWe,                        // Internal RAM write strobe
   output logic [7:0] iramAddr,                // Internal RAM address
   output logic [7:0] iramData,                // Internal RAM data
   output logic byteDropped,                   // Pulse: byte outside the writable map discarded
   output logic factoryOnly,                   // Retest recognised
   output logic bootDone,                      // Boot finished
   output logic debugPortOpen,                 // Debug port enabled
   output logic eepromLock,                    // EEPROM access lock bit
   output logic nvmLock,                       // NVM access lock bit
   output logic [7:0] eeRdDataOut,             // EEPROM read data to CPU
   output logic eeWrOut,                       // EEPROM write passed on
   output logic nvmGrant,                      // Pulse: NVM operation allowed
   output logic nvmDeny,                       // Pulse: NVM operation refused
   output logic protWrRefused,                 // Pulse: protection write refused
   output logic [7:0] retestProtectionByte     // Stored protection byte
);
   import boot_pkg::*;

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   if (XRAM_FACTORY_BASE == 16'h0000 || XRAM_FACTORY_BASE > XRAM_HI) begin : g_bad_base
      $error("factory base outside code/xdata RAM");
   end
   if (SEQ_LEN < 2 || SEQ_LEN > 4 || NVM_BYTES != 8192) begin : g_bad_len
      $error("unsupported pattern length or NVM size");
   end

   localparam logic [12:0] NVM_TAIL_START = 13'(NVM_BYTES - NVM_TAIL);

   boot_wr_if wr ();

   boot_addr_map u_map (
      .clk(clk),
      .rst_n(rst_n),
      .wr(wr)
   );

   state_t state_r;
   logic pinS1, pinS2, pinS3, pinLevel_r;
   logic [5:0] tickCnt_r;
   logic tick;
   logic [1:0] seqCnt_r;
   logic [3:0] seqShift_r;
   logic [3:0] seqNxt;
   logic runLevel_r, retest_r, kill_r;
   logic [15:0] clrAddr_r;
   logic frameTake;

   // ------------------------------------------------------------
   // Retest pin synchroniser and sample tick
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinS1 <= 1'b0;
         pinS2 <= 1'b0;
         pinS3 <= 1'b0;
         pinLevel_r <= 1'b0;
      end else begin
         pinS1 <= retestPin;
         pinS2 <= pinS1;
         pinS3 <= pinS2;
         // Change accepted only once two stages agree
         if (pinS2 == pinS3) begin
            pinLevel_r <= pinS3;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || state_r != ST_SAMPLE) begin
         tickCnt_r <= 6'h00;
      end else if (tickCnt_r == 6'(TICK_CYC - 1)) begin
         tickCnt_r <= 6'h00;
      end else begin
         tickCnt_r <= tickCnt_r + 6'h01;
      end
   end
   assign tick = (state_r == ST_SAMPLE) && (tickCnt_r == 6'(TICK_CYC - 1));
   assign seqNxt = {seqShift_r[2:0], pinLevel_r};
   assign frameTake = frameValid && frameReady;

   // ------------------------------------------------------------
   // Boot sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         seqCnt_r <= 2'h0;
         seqShift_r <= 4'h0;
         runLevel_r <= 1'b0;
         retest_r <= 1'b0;
         kill_r <= 1'b0;
         clrAddr_r <= 16'h0000;
         frameReady <= 1'b0;
         bootDone <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (bootStart) begin
                  state_r <= ST_SAMPLE;
                  runLevel_r <= (progLevel == LVL_RUN);
                  kill_r <= debugPortKill && (progLevel == LVL_RUN);
                  seqCnt_r <= 2'h0;
                  seqShift_r <= 4'h0;
               end
            end
            ST_SAMPLE: begin
               if (tick) begin
                  seqShift_r <= seqNxt;
                  seqCnt_r <= seqCnt_r + 2'h1;
                  if (seqCnt_r == 2'(SEQ_LEN - 1)) begin
                     // Only a Run part can be pulled into retest
                     retest_r <= runLevel_r && (seqNxt[SEQ_LEN-1:0] == RETEST_SEQ[SEQ_LEN-1:0]);
                     state_r <= ST_LOAD;
                     frameReady <= 1'b1;
                  end
               end
            end
            ST_LOAD: begin
               // User blocks keep coming until the image ends
               if (frameTake && frameEnd) begin
                  frameReady <= 1'b0;
                  if (retest_r && !kill_r && retestProtectionByte[BIT_RAM_CLEAR]) begin
                     state_r <= ST_CLR_X;
                     clrAddr_r <= 16'h0000;
                  end else begin
                     state_r <= ST_FINISH;
                  end
               end
            end
            ST_CLR_X: begin
               if (clrAddr_r == XRAM_FACTORY_BASE - 16'h0001) begin
                  state_r <= ST_CLR_I;
                  clrAddr_r <= {IWIN_PAGE, IRAM_CLR_FIRST};
               end else begin
                  clrAddr_r <= clrAddr_r + 16'h0001;
               end
            end
            ST_CLR_I: begin
               if (clrAddr_r[7:0] == IRAM_LAST) begin
                  state_r <= ST_FINISH;
               end else begin
                  clrAddr_r <= clrAddr_r + 16'h0001;
               end
            end
            ST_FINISH: begin
               bootDone <= 1'b1;
               state_r <= ST_DONE;
            end
            ST_DONE: begin
               state_r <= ST_DONE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Write requests toward the address mapper
   // ------------------------------------------------------------
   always_comb begin
      wr.req = 1'b0;
      wr.clr = 1'b0;
      wr.addr = frameAddr;
      wr.data = frameData;
      if (state_r == ST_LOAD) begin
         // In retest the user blocks are read but never land
         wr.req = frameTake && !(frameUser && retest_r);
      end else if (state_r == ST_CLR_X || state_r == ST_CLR_I) begin
         wr.req = 1'b1;
         wr.clr = 1'b1;
         wr.addr = clrAddr_r;
         wr.data = 8'h00;
      end
   end

   assign xramWe = wr.xWe;
   assign xramAddr = wr.xAddr;
   assign xramData = wr.xData;
   assign iramWe = wr.iWe;
   assign iramAddr = wr.iAddr;
   assign iramData = wr.iData;
   assign byteDropped = wr.drop;

   // ------------------------------------------------------------
   // Protection byte and lock bits
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         retestProtectionByte <= PROT_RESET;
         protWrRefused <= 1'b0;
      end else begin
         protWrRefused <= 1'b0;
         if (state_r == ST_IDLE && bootStart) begin
            retestProtectionByte <= protNvmByte;
         end else if (protWrReq) begin
            if (runLevel_r) begin
               protWrRefused <= 1'b1;
            end else begin
               // Bits only ever go from zero to one
               retestProtectionByte <= retestProtectionByte | protWrData;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eepromLock <= 1'b0;
         nvmLock <= 1'b0;
         factoryOnly <= 1'b0;
         debugPortOpen <= 1'b0;
      end else if (state_r == ST_FINISH) begin
         factoryOnly <= retest_r;
         // Flags count only in retest of a Run part, never after a kill
         eepromLock <= retest_r && !kill_r && retestProtectionByte[BIT_EE_LOCK];
         nvmLock <= retest_r && !kill_r && retestProtectionByte[BIT_NVM_LOCK];
      end else if (state_r == ST_DONE) begin
         // Opens one cycle after every lock and clear has finished
         debugPortOpen <= !kill_r && (!runLevel_r || retest_r);
      end
   end

   // ------------------------------------------------------------
   // EEPROM and NVM access gates
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eeRdDataOut <= EE_LOCKED_DATA;
         eeWrOut <= 1'b0;
      end else begin
         eeRdDataOut <= eepromLock ? EE_LOCKED_DATA : eeRdData;
         eeWrOut <= eeWrReq && !eepromLock;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nvmGrant <= 1'b0;
         nvmDeny <= 1'b0;
      end else if (!nvmReqValid) begin
         nvmGrant <= 1'b0;
         nvmDeny <= 1'b0;
      end else if (!nvmLock) begin
         nvmGrant <= 1'b1;
         nvmDeny <= 1'b0;
      end else begin
         case (nvmReqKind)
            NVM_CRC_FACTORY, NVM_CRC_USER: begin
               nvmGrant <= 1'b1;
               nvmDeny <= 1'b0;
            end
            NVM_RD: begin
               nvmGrant <= nvmReqAddr >= NVM_TAIL_START;
               nvmDeny <= nvmReqAddr < NVM_TAIL_START;
            end
            default: begin
               nvmGrant <= 1'b0;
               nvmDeny <= 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_finish;
      state_r == ST_FINISH ##1 state_r == ST_DONE;
   endsequence
   property p_run_closed;
      (runLevel_r && !retest_r) ##0 s_finish |=> !debugPortOpen [*4];
   endproperty
   a_run_closed: assert property (p_run_closed) else $error("run part opened debug port");
   property p_kill;
      kill_r |-> !debugPortOpen;
   endproperty
   a_kill: assert property (p_kill) else $error("debug port open despite kill");
   property p_open_after_locks;
      $rose(debugPortOpen) |-> $past(state_r, 2) == ST_FINISH && $past(eepromLock) == eepromLock;
   endproperty
   a_open_after_locks: assert property (p_open_after_locks) else $error("port opened before locks");
   property p_ee_locked;
      $past(eepromLock) |-> eeRdDataOut == EE_LOCKED_DATA && !eeWrOut;
   endproperty
   a_ee_locked: assert property (p_ee_locked) else $error("locked EEPROM leaked access");
   property p_no_run_flags;
      !runLevel_r |-> !eepromLock && !nvmLock;
   endproperty
   a_no_run_flags: assert property (p_no_run_flags) else $error("flags applied outside Run");
   property p_user_skip;
      state_r == ST_LOAD && retest_r && frameTake && frameUser |=> !xramWe && !iramWe;
   endproperty
   a_user_skip: assert property (p_user_skip) else $error("user byte written in retest");
   property p_iwin;
      iramWe && $past(state_r) == ST_LOAD |-> iramAddr >= IWR_LO[7:0] && iramAddr <= IWR_HI[7:0];
   endproperty
   a_iwin: assert property (p_iwin) else $error("loader wrote protected internal RAM");
   property p_nvm_tail;
      nvmGrant && $past(nvmLock) && $past(nvmReqKind) == NVM_RD |-> $past(nvmReqAddr) >= NVM_TAIL_START;
   endproperty
   a_nvm_tail: assert property (p_nvm_tail) else $error("locked NVM read granted");
   property p_prot_refuse;
      protWrReq && runLevel_r && state_r != ST_IDLE |=> protWrRefused && $stable(retestProtectionByte);
   endproperty
   a_prot_refuse: assert property (p_prot_refuse) else $error("protection changed in Run");
endmodule

//--- include/boot_pkg.sv
// Constants and types shared by the boot loader and its address mapper
package boot_pkg;
   // ------------------------------------------------------------
   // Destination address map
   // ------------------------------------------------------------
   localparam logic [15:0] XRAM_HI = 16'h11ff;
   localparam logic [15:0] XRAM_FACTORY_BASE_DEF = 16'h1000;
   localparam logic [15:0] IWIN_LO = 16'h7000;
   localparam logic [15:0] IWIN_HI = 16'h70ff;
   localparam logic [15:0] IWR_LO = 16'h7020;
   localparam logic [15:0] IWR_HI = 16'h70ef;
   localparam logic [7:0] IWIN_PAGE = 8'h70;
   localparam logic [7:0] IRAM_CLR_FIRST = 8'h08;
   localparam logic [7:0] IRAM_LAST = 8'hff;
   // ------------------------------------------------------------
   // Retest protection byte layout
   // ------------------------------------------------------------
   localparam int BIT_NVM_LOCK = 7;
   localparam int BIT_EE_LOCK = 6;
   localparam int BIT_RAM_CLEAR = 5;
   localparam logic [7:0] PROT_RESET = 8'h00;
   localparam logic [7:0] EE_LOCKED_DATA = 8'h00;
   // ------------------------------------------------------------
   // NVM and timing
   // ------------------------------------------------------------
   localparam int NVM_BYTES_DEF = 8192;
   localparam int NVM_TAIL = 64;
   localparam int CLK_NS = 25;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int SEQ_LEN_DEF = 4;
   localparam logic [3:0] RETEST_SEQ_DEF = 4'ha;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LVL_FACTORY = 2'h0,
      LVL_USER = 2'h1,
      LVL_RUN = 2'h2
   } level_t;
   typedef enum logic [1:0] {
      NVM_RD = 2'h0,
      NVM_WR = 2'h1,
      NVM_CRC_FACTORY = 2'h2,
      NVM_CRC_USER = 2'h3
   } nvm_op_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SAMPLE = 3'h1,
      ST_LOAD = 3'h3,
      ST_CLR_X = 3'h2,
      ST_CLR_I = 3'h6,
      ST_FINISH = 3'h7,
      ST_DONE = 3'h5
   } state_t;
endpackage

//--- include/boot_wr_if.sv
// Write request from the loader and decoded RAM writes from the mapper
interface boot_wr_if;
   logic req;
   logic clr;
   logic [15:0] addr;
   logic [7:0] data;
   logic xWe;
   logic [12:0] xAddr;
   logic [7:0] xData;
   logic iWe;
   logic [7:0] iAddr;
   logic [7:0] iData;
   logic drop;
   modport src (output req, clr, addr, data, input xWe, xAddr, xData, iWe, iAddr, iData, drop);
   modport map (input req, clr, addr, data, output xWe, xAddr, xData, iWe, iAddr, iData, drop);
endinterface

//--- tb/boot_loader_retest_protection_test.sv
// Self-checking bench for the boot loader and retest protection
module boot_loader_retest_protection_test;
   timeunit 1ns;
   timeprecision 100ps;
   import boot_pkg::*;
   localparam logic [15:0] FBASE = 16'h0010;
   logic clk, rst_n, bootStart, retestPin, debugPortKill, protWrReq, frameValid, frameUser, frameEnd;
   logic eeWrReq, nvmReqValid, sendRetest, frameReady, xramWe, iramWe, byteDropped, factoryOnly;
   logic bootDone, debugPortOpen, eepromLock, nvmLock, eeWrOut, nvmGrant, nvmDeny, protWrRefused;
   level_t progLevel;
   nvm_op_t nvmReqKind;
   logic [7:0] protNvmByte, protWrData, frameData, eeRdData, xramData, iramAddr, iramData;
   logic [7:0] eeRdDataOut, retestProtectionByte, lastXd, lastI, lastId, iMin, iMax;
   logic [15:0] frameAddr;
   logic [12:0] nvmReqAddr, xramAddr, lastX;
   int fail_count = 0, tests_run = 0, xCnt, xNz, iCnt, iNz, dCnt, early;
   nvm_op_t ops[5] = '{NVM_RD, NVM_RD, NVM_WR, NVM_CRC_FACTORY, NVM_CRC_USER};
   logic [12:0] adrs[5] = '{13'(NVM_BYTES_DEF - NVM_TAIL), 13'(NVM_BYTES_DEF - NVM_TAIL - 1), 13'h0, 13'h0, 13'h0};
   logic lockOk[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

   boot_loader_retest_protection #(.XRAM_FACTORY_BASE(FBASE)) u_boot_loader_retest_protection (
      .clk(clk), .rst_n(rst_n), .bootStart(bootStart), .progLevel(progLevel), .retestPin(retestPin),
      .protNvmByte(protNvmByte), .debugPortKill(debugPortKill), .protWrReq(protWrReq),
      .protWrData(protWrData), .frameValid(frameValid), .frameAddr(frameAddr), .frameData(frameData),
      .frameUser(frameUser), .frameEnd(frameEnd), .eeRdData(eeRdData), .eeWrReq(eeWrReq),
      .nvmReqValid(nvmReqValid), .nvmReqKind(nvmReqKind), .nvmReqAddr(nvmReqAddr),
      .frameReady(frameReady), .xramWe(xramWe), .xramAddr(xramAddr), .xramData(xramData),
      .iramWe(iramWe), .iramAddr(iramAddr), .iramData(iramData), .byteDropped(byteDropped),
      .factoryOnly(factoryOnly), .bootDone(bootDone), .debugPortOpen(debugPortOpen),
      .eepromLock(eepromLock), .nvmLock(nvmLock), .eeRdDataOut(eeRdDataOut), .eeWrOut(eeWrOut),
      .nvmGrant(nvmGrant), .nvmDeny(nvmDeny), .protWrRefused(protWrRefused),
      .retestProtectionByte(retestProtectionByte));
   retest_tester_model u_retest_tester_model (.clk(clk), .bootStart(bootStart), .sendRetest(sendRetest),
      .retestPin(retestPin));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Write monitor
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (xramWe === 1'b1) begin
         xCnt++;
         xNz += (xramData !== 8'h00);
         lastX = xramAddr;
         lastXd = xramData;
      end
      if (iramWe === 1'b1) begin
         iCnt++;
         iNz += (iramData !== 8'h00);
         lastI = iramAddr;
         lastId = iramData;
         if (iramAddr < iMin) iMin = iramAddr;
         if (iramAddr > iMax) iMax = iramAddr;
      end
      dCnt += (byteDropped === 1'b1);
      early += (debugPortOpen === 1'b1 && (xramWe === 1'b1 || iramWe === 1'b1));
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task end_sim;
      if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task wait_for(input bit done, input int lim);
      int k;
      k = 0;
      while (((done ? bootDone : frameReady) !== 1'b1) && k < lim) begin
         step(1);
         k++;
      end
      if (k >= lim) begin
         fail_count++;
         end_sim;
      end
   endtask
   task rst;
      rst_n = 1'b0;
      step(6);
      rst_n = 1'b1;
      {xCnt, xNz, iCnt, iNz, dCnt, early} = '0;
      iMin = 8'hff;
      iMax = 8'h00;
      step(3);
   endtask
   task boot(input level_t lv, input logic [7:0] pb, input logic kill, input logic rt);
      progLevel = lv;
      protNvmByte = pb;
      debugPortKill = kill;
      sendRetest = rt;
      bootStart = 1'b1;
      step(1);
      bootStart = 1'b0;
      wait_for(0, 300);
   endtask
   task send(input logic [15:0] a, input logic [7:0] d, input logic u, input logic e);
      frameAddr = a;
      frameData = d;
      frameUser = u;
      frameEnd = e;
      frameValid = 1'b1;
      step(1);
   endtask
   task finish_boot;
      frameValid = 1'b0;
      frameEnd = 1'b0;
      wait_for(1, 600);
      step(2);
   endtask
   task probe(input logic lk);
      eeRdData = 8'h77;
      eeWrReq = 1'b1;
      step(2);
      chk("eeRd", eeRdDataOut, lk ? EE_LOCKED_DATA : 8'h77);
      chk("eeWr", eeWrOut, !lk);
      eeWrReq = 1'b0;
      for (int i = 0; i < 5; i++) begin
         nvmReqKind = ops[i];
         nvmReqAddr = adrs[i];
         nvmReqValid = 1'b1;
         step(1);
         chk("nvmGrant", nvmGrant, lk ? lockOk[i] : 1'b1);
         chk("nvmDeny", nvmDeny, lk ? !lockOk[i] : 1'b0);
         nvmReqValid = 1'b0;
         step(1);
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task sc_user;
      rst;
      protWrReq = 1'b1;
      protWrData = 8'h80;
      step(1);
      protWrData = 8'h20;
      step(1);
      protWrData = 8'h00;
      step(1);
      protWrReq = 1'b0;
      step(1);
      chk("protByte", retestProtectionByte, 8'ha0);
      boot(LVL_USER, 8'he0, 1'b0, 1'b0);
      send(16'h0005, 8'h11, 1, 0);
      send(XRAM_HI, 8'h22, 1, 0);
      send(16'h7056, 8'ha4, 1, 0);
      send(16'h701f, 8'h33, 1, 0);
      send(16'h70f0, 8'h44, 1, 0);
      send(16'h1200, 8'h55, 1, 1);
      finish_boot;
      chk("xCnt", xCnt, 2);
      chk("lastX", {lastX, lastXd}, {XRAM_HI[12:0], 8'h22});
      chk("iram", {lastI, lastId}, 16'h56a4);
      chk("iCnt", iCnt, 1);
      chk("drops", dCnt, 3);
      chk("locks", {eepromLock, nvmLock, factoryOnly}, 0);
      probe(1'b0);
   endtask
   task sc_run;
      rst;
      boot(LVL_RUN, 8'he0, 1'b0, 1'b0);
      send(16'h0003, 8'h66, 1, 1);
      finish_boot;
      chk("xCnt", xCnt, 1);
      chk("open", debugPortOpen, 0);
      chk("locks", {eepromLock, nvmLock, factoryOnly}, 0);
      protWrData = 8'h01;
      protWrReq = 1'b1;
      step(1);
      protWrReq = 1'b0;
      chk("refused", protWrRefused, 1);
      chk("protByte", retestProtectionByte, 8'he0);
   endtask
   task sc_retest(input logic kill);
      rst;
      boot(LVL_RUN, 8'he0, kill, 1'b1);
      send(16'h0003, 8'h66, 1, 0);
      send(16'h0008, 8'h5a, 0, 1);
      finish_boot;
      if (!kill) begin
         chk("factoryOnly", factoryOnly, 1);
         chk("xCnt", xCnt, FBASE + 1);
         chk("xNz", xNz, 1);
         chk("iCnt", iCnt, 16'h100 - IRAM_CLR_FIRST);
         chk("iRange", {iMin, iMax, 8'(iNz)}, {IRAM_CLR_FIRST, IRAM_LAST, 8'h00});
         chk("early", early, 0);
         chk("open", debugPortOpen, 1);
         chk("locks", {eepromLock, nvmLock}, 2'b11);
         probe(1'b1);
      end else begin
         step(10);
         chk("open", debugPortOpen, 0);
         chk("locks", {eepromLock, nvmLock}, 0);
         chk("xCnt", xCnt, 1);
      end
   endtask

   initial begin
      {rst_n, bootStart, debugPortKill, protWrReq, frameValid, frameUser, frameEnd} = '0;
      {eeWrReq, nvmReqValid, sendRetest, protNvmByte, protWrData, frameData, eeRdData} = '0;
      progLevel = LVL_FACTORY;
      nvmReqKind = NVM_RD;
      frameAddr = 16'h0000;
      nvmReqAddr = 13'h0000;
      sc_user;
      sc_run;
      sc_retest(1'b0);
      sc_retest(1'b1);
      end_sim;
   end
endmodule

//--- tb/retest_tester_model.sv
// Tester model driving the retest pin pattern during the boot sample phase
module retest_tester_model #(
   parameter logic [3:0] SEQ = boot_pkg::RETEST_SEQ_DEF, // Pattern, sent MSB first
   parameter int SPAN = boot_pkg::TICK_CYC               // Cycles per pattern bit
) (
   input wire logic clk,        // System clock
   input wire logic bootStart,  // Boot start pulse
   input wire logic sendRetest, // Send the true pattern
   output logic retestPin       // Tester pin
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 1000;
   logic [3:0] pat = 4'h0;
   always @(posedge clk) begin
      if (bootStart) begin
         cnt <= 0;
         // Inverted pattern keeps a plain boot honest
         pat <= sendRetest ? SEQ : ~SEQ;
      end else if (cnt < 4 * SPAN) begin
         cnt <= cnt + 1;
      end
   end
   // Each bit held a full tick so the synchroniser lag never matters
   always_comb retestPin = (cnt < 4 * SPAN) ? pat[3 - cnt / SPAN] : 1'b0;
endmodule
